// *** src/instr_exec_call_clr_dec.sv ***
// Executes call, watchdog kick, clear, invert and decrement instructions.
//
// What this block does
// - A call pushes the next instruction address on the same edge that changes the PC.
// - A call loads its 11-bit literal into PC bits 10 to 0.
// - A call takes PC bits 12 and 11 from page latch bits 4 and 3.
// - A call takes two cycles and leaves all status flags alone.
// - A watchdog kick clears the watchdog counter and its prescaler.
// - A watchdog kick sets the timer-expiry and sleep flags.
// - Register clear writes zero to the register and sets zero flag.
// - Accumulator clear writes zero to the accumulator, sets zero flag.
// - Register invert complements the register and updates zero flag.
// - Destination 0 goes to accumulator, 1 back to the register.
// - Decrement subtracts one, writes destination, updates zero flag.
// - Decrement-skip subtracts one, writes destination, flags unchanged.
// - Decrement-skip with zero result replaces next instruction by nop.
`timescale 1ns/1ps
module instr_exec_call_clr_dec
  import exec_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic instr_valid,
  input wire op_t instr_op,
  input wire logic [10:0] instr_lit,
  input wire logic [6:0] instr_faddr,
  input wire logic instr_dest,
  input wire logic [7:0] page_latch,
  input wire logic [7:0] freg_rdata,
  output logic [6:0] freg_raddr,
  output logic freg_we,
  output logic [6:0] freg_waddr,
  output logic [7:0] freg_wdata,
  output logic [7:0] accumulator,
  output logic zero_flag,
  output logic timer_expiry_flag,
  output logic sleep_flag,
  output logic dog_timer_clear,
  output logic [12:0] pc,
  output logic [12:0] stack_top,
  output logic busy,
  output logic flushing
);
  ////////////////////////////////////////////////////////////////////////////
  state_t state;
  logic [7:0] result;
  logic result_zero;
  logic take;
  logic [12:0] next_pc;
  logic [12:0] ret_addr;
  logic do_call;
  logic do_kick;
  logic do_skip_zero;
  logic skip_slot;

  ////////////////////////////////////////////////////////////////////////////
  // Opcode classes for the call, kick and skip decodes. Each one is tested
  // in a single place below.
  function automatic logic op_is_call(input op_t op);
    return op == OP_CALL;
  endfunction

  function automatic logic op_is_kick(input op_t op);
    return op == OP_KICK;
  endfunction

  function automatic logic op_is_skip(input op_t op);
    return op == OP_MINUS_SKIP;
  endfunction

  // The page bits above the literal come from the latch, so software must
  // set the latch before a call that leaves the current page.
  function automatic logic [12:0] call_target(input logic [7:0] latch,
      input logic [10:0] lit);
    return {latch[PAGE_HI:PAGE_LO], lit};
  endfunction

  // Wraps at the top of the program space, as the counter has no carry out.
  function automatic logic [12:0] pc_after(input logic [12:0] addr);
    return addr + PC_STEP;
  endfunction

  // Operand read is combinational so the result is ready in the taking cycle.
  assign freg_raddr = instr_faddr;
  assign take = instr_valid && (state == ST_EXEC);
  assign ret_addr = pc_after(pc);
  assign do_call = take && op_is_call(instr_op);
  assign do_kick = take && op_is_kick(instr_op);
  assign do_skip_zero = take && op_is_skip(instr_op) && result_zero;
  assign busy = (state != ST_EXEC);
  assign flushing = (state == ST_FLUSH);

  alu_unit u_alu (
    .op(instr_op),
    .operand(freg_rdata),
    .result(result),
    .zero(result_zero)
  );

  return_stack u_stack (
    .clk(clk),
    .nrst(nrst),
    .push(do_call),
    .push_addr(ret_addr),
    .stack_top(stack_top)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing: a call or a taken skip spends a second cycle as a nop.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_EXEC;
    end else begin
      unique case (state)
        ST_EXEC: begin
          if (do_call) begin
            state <= ST_FLUSH;
          end else if (do_skip_zero) begin
            state <= ST_FLUSH;
          end
        end
        ST_FLUSH: state <= ST_EXEC;
        default: state <= ST_EXEC;
      endcase
    end
  end

  always_comb begin
    next_pc = pc;
    if (do_call) begin
      next_pc = call_target(page_latch, instr_lit);
    end else if (take) begin
      next_pc = ret_addr;
    end else if (state == ST_FLUSH && skip_slot) begin
      // Only a skip slot steps past the discarded instruction; after a call
      // the pc already names the target, which must not be passed over.
      next_pc = ret_addr;
    end
  end

  // The push samples pc in the same edge that replaces it, so the value
  // stacked is the old pc plus one.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pc <= PC_RESET;
    end else begin
      pc <= next_pc;
    end
  end

  // Remembers whether the coming nop slot belongs to a skip or to a call.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      skip_slot <= 1'b0;
    end else if (state == ST_EXEC) begin
      skip_slot <= do_skip_zero;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Accumulator writes.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      accumulator <= BYTE_ZERO;
    end else if (take) begin
      unique case (instr_op)
        OP_ACC_CLEAR: accumulator <= BYTE_ZERO;
        OP_REG_INVERT, OP_REG_MINUS, OP_MINUS_SKIP: begin
          if (instr_dest == DEST_ACC) begin
            accumulator <= result;
          end
        end
        default: accumulator <= accumulator;
      endcase
    end
  end

  // File register writes are registered one-cycle strobes.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      freg_we <= 1'b0;
      freg_waddr <= '0;
      freg_wdata <= BYTE_ZERO;
    end else begin
      freg_we <= 1'b0;
      if (take) begin
        freg_waddr <= instr_faddr;
        unique case (instr_op)
          OP_REG_CLEAR: begin
            freg_we <= 1'b1;
            freg_wdata <= BYTE_ZERO;
          end
          OP_REG_INVERT, OP_REG_MINUS, OP_MINUS_SKIP: begin
            freg_we <= (instr_dest == DEST_REG);
            freg_wdata <= result;
          end
          default: freg_we <= 1'b0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Zero flag: call and decrement-skip fall to the default and hold it.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      zero_flag <= 1'b0;
    end else if (take) begin
      unique case (instr_op)
        OP_REG_CLEAR, OP_ACC_CLEAR: zero_flag <= 1'b1;
        OP_REG_INVERT: zero_flag <= result_zero;
        OP_REG_MINUS: zero_flag <= result_zero;
        default: zero_flag <= zero_flag;
      endcase
    end
  end

  // Power-up leaves both flags set, matching a cold start.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      timer_expiry_flag <= 1'b1;
      sleep_flag <= 1'b1;
    end else if (do_kick) begin
      timer_expiry_flag <= 1'b1;
      sleep_flag <= 1'b1;
    end
  end

  // One pulse clears both the watchdog counter and its prescaler outside.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dog_timer_clear <= 1'b0;
    end else begin
      dog_timer_clear <= do_kick;
    end
  end
endmodule

// *** src/exec_pkg.sv ***
// Package with opcodes, widths, field positions and reset values.
package exec_pkg;
  localparam int DATA_W = 8;
  localparam int PC_W = 13;
  localparam int LIT_W = 11;
  localparam int FADDR_W = 7;
  localparam int STACK_DEPTH = 8;
  localparam int STACK_PTR_W = 3;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [12:0] PC_RESET = 13'h0000;
  localparam logic [12:0] PC_STEP = 13'h0001;
  localparam int PAGE_HI = 4;
  localparam int PAGE_LO = 3;
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_REG = 1'b1;

  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_CALL = 4'h1,
    OP_KICK = 4'h2,
    OP_REG_CLEAR = 4'h3,
    OP_ACC_CLEAR = 4'h4,
    OP_REG_INVERT = 4'h5,
    OP_REG_MINUS = 4'h6,
    OP_MINUS_SKIP = 4'h7
  } op_t;

  typedef enum logic [1:0] {
    ST_EXEC = 2'b00,
    ST_FLUSH = 2'b01
  } state_t;
endpackage

// *** src/alu_unit.sv ***
// Eight-bit result path for clear, invert and decrement.
`timescale 1ns/1ps
module alu_unit
  import exec_pkg::*;
(
  input wire op_t op,
  input wire logic [7:0] operand,
  output logic [7:0] result,
  output logic zero
);
  always_comb begin
    unique case (op)
      OP_REG_INVERT: result = ~operand;
      OP_REG_MINUS, OP_MINUS_SKIP: result = operand - BYTE_ONE;
      default: result = BYTE_ZERO;
    endcase
    zero = (result == BYTE_ZERO);
  end
endmodule

// *** src/return_stack.sv ***
// Return address stack, pushed on subroutine jumps.
`timescale 1ns/1ps
module return_stack
  import exec_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic push,
  input wire logic [12:0] push_addr,
  output logic [12:0] stack_top
);
  logic [12:0] mem [STACK_DEPTH];
  logic [STACK_PTR_W-1:0] ptr;
  logic [STACK_PTR_W-1:0] top_idx;

  // The top is the slot written last, one below the free pointer.
  assign top_idx = ptr - 1'b1;
  assign stack_top = mem[top_idx];

  // Circular stack: overflow silently wraps, as the core has no trap.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ptr <= '0;
    end else if (push) begin
      ptr <= ptr + 1'b1;
    end
  end

  // Every slot resets, so the top reads as a clean address before any push.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < STACK_DEPTH; i++) begin
        mem[i] <= PC_RESET;
      end
    end else if (push) begin
      mem[ptr] <= push_addr;
    end
  end
endmodule

// *** dv/instr_exec_checker.sv ***
// Port-level assertions for the call, clear and decrement block.
`timescale 1ns/1ps
module instr_exec_checker
  import exec_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic instr_valid,
  input wire op_t instr_op,
  input wire logic [10:0] instr_lit,
  input wire logic [6:0] instr_faddr,
  input wire logic instr_dest,
  input wire logic [7:0] page_latch,
  input wire logic [7:0] freg_rdata,
  input wire logic freg_we,
  input wire logic [6:0] freg_waddr,
  input wire logic [7:0] freg_wdata,
  input wire logic [7:0] accumulator,
  input wire logic zero_flag,
  input wire logic timer_expiry_flag,
  input wire logic sleep_flag,
  input wire logic dog_timer_clear,
  input wire logic [12:0] pc,
  input wire logic [12:0] stack_top,
  input wire logic busy
);
  logic go;
  assign go = instr_valid && !busy;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  //////////////////////////////////////////////////////////////////////////
  property p_call_push;
    go && instr_op == OP_CALL |=> stack_top == $past(pc) + PC_STEP;
  endproperty
  a_call_push: assert property (p_call_push)
    else $error("return address wrong");
  property p_call_lo;
    go && instr_op == OP_CALL |=> pc[10:0] == $past(instr_lit);
  endproperty
  a_call_lo: assert property (p_call_lo)
    else $error("call low bits wrong");
  property p_call_hi;
    go && instr_op == OP_CALL |=> pc[12:11] == $past(page_latch[4:3]);
  endproperty
  a_call_hi: assert property (p_call_hi)
    else $error("call page bits wrong");
  property p_call_two;
    go && instr_op == OP_CALL |=> busy && $stable(zero_flag)
      ##1 !busy && $stable(pc);
  endproperty
  a_call_two: assert property (p_call_two)
    else $error("call timing or flag wrong");
  property p_kick;
    go && instr_op == OP_KICK |=> dog_timer_clear && timer_expiry_flag
      && sleep_flag;
  endproperty
  a_kick: assert property (p_kick)
    else $error("kick result wrong");
  property p_clear;
    go && instr_op == OP_REG_CLEAR |=> freg_we && zero_flag
      && freg_wdata == BYTE_ZERO && freg_waddr == $past(instr_faddr);
  endproperty
  a_clear: assert property (p_clear)
    else $error("register clear wrong");
  property p_acc_clr;
    go && instr_op == OP_ACC_CLEAR |=> accumulator == BYTE_ZERO && zero_flag;
  endproperty
  a_acc_clr: assert property (p_acc_clr)
    else $error("accumulator clear wrong");
  property p_inv;
    go && instr_op == OP_REG_INVERT && instr_dest == DEST_ACC
      |=> accumulator == ~$past(freg_rdata)
      && zero_flag == (~$past(freg_rdata) == BYTE_ZERO);
  endproperty
  a_inv: assert property (p_inv)
    else $error("invert wrong");
  property p_dec;
    go && instr_op == OP_REG_MINUS && instr_dest == DEST_REG
      |=> freg_we && freg_wdata == $past(freg_rdata) - BYTE_ONE;
  endproperty
  a_dec: assert property (p_dec)
    else $error("decrement wrong");
  property p_skip;
    go && instr_op == OP_MINUS_SKIP && freg_rdata == BYTE_ONE
      |=> busy && $stable(zero_flag)
      ##1 !busy && pc == $past(pc) + PC_STEP;
  endproperty
  a_skip: assert property (p_skip)
    else $error("skip wrong");
  c_call: cover property (go && instr_op == OP_CALL);
  c_kick: cover property (go && instr_op == OP_KICK);
  c_skip: cover property (go && instr_op == OP_MINUS_SKIP ##1 busy);
endmodule
bind instr_exec_call_clr_dec instr_exec_checker u_instr_exec_checker (.*);

// *** dv/instr_exec_call_clr_dec_tb.sv ***
// Self-checking bench for the call, clear and decrement block.
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
  error_cnt++; $display("CHECK FAILED %0t %h %h", $time, a, b); end end
module instr_exec_call_clr_dec_tb
  import exec_pkg::*;
;
  logic clk, nrst, instr_valid, instr_dest, freg_we, zero_flag, busy;
  logic timer_expiry_flag, sleep_flag, dog_timer_clear, flushing;
  op_t instr_op;
  logic [10:0] instr_lit;
  logic [6:0] instr_faddr, freg_raddr, freg_waddr;
  logic [7:0] page_latch, freg_rdata, freg_wdata, accumulator;
  logic [12:0] pc, stack_top, p;
  int error_cnt = 0;
  int check_count = 0;
  instr_exec_call_clr_dec u_instr_exec_call_clr_dec (.*);
  always #25 clk = ~clk;
  //////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Results are sampled 1 ns after the taking edge, once they have landed.
  task automatic issue(input op_t o, input logic [10:0] l,
      input logic [7:0] r, input logic d);
    for (int i = 0; i < 4 && busy !== 1'h0; i++) @(posedge clk) #1;
    if (busy !== 1'h0) begin
      error_cnt++;
      give_verdict();
    end
    @(posedge clk);
    instr_valid <= 1'h1;
    instr_op <= o;
    instr_lit <= l;
    instr_faddr <= l[6:0];
    freg_rdata <= r;
    instr_dest <= d;
    @(posedge clk);
    instr_valid <= 1'h0;
    #1;
  endtask
  task automatic t_call();
    @(posedge clk);
    page_latch <= 8'hf7;
    #1;
    p = pc;
    issue(OP_CALL, 11'h555, 8'h00, 1'h0);
    `CHK(pc, 13'h1555)
    `CHK(stack_top, p + 13'h0001)
    `CHK(busy, 1'h1)
    @(posedge clk) #1;
    `CHK({busy, pc}, {1'h0, 13'h1555})
    @(posedge clk);
    page_latch <= 8'h0b;
    issue(OP_CALL, 11'h0aa, 8'h00, 1'h0);
    `CHK({pc, stack_top}, {13'h08aa, 13'h1556})
  endtask
  task automatic t_kick();
    issue(OP_KICK, 11'h000, 8'h00, 1'h0);
    `CHK({dog_timer_clear, timer_expiry_flag, sleep_flag}, 3'h7)
    @(posedge clk) #1;
    `CHK(dog_timer_clear, 1'h0)
  endtask
  task automatic t_clear();
    issue(OP_REG_CLEAR, 11'h07f, 8'h5a, 1'h1);
    `CHK({freg_we, freg_waddr, freg_wdata, zero_flag}, 17'h1_fe01)
    issue(OP_REG_INVERT, 11'h001, 8'h0f, 1'h0);
    `CHK({accumulator, zero_flag}, 9'h1e0)
    issue(OP_REG_INVERT, 11'h002, 8'hff, 1'h1);
    `CHK({freg_we, freg_wdata, zero_flag}, 10'h201)
    issue(OP_ACC_CLEAR, 11'h000, 8'h33, 1'h0);
    `CHK({accumulator, zero_flag}, 9'h001)
  endtask
  task automatic t_dec();
    issue(OP_REG_MINUS, 11'h003, 8'h01, 1'h1);
    `CHK({freg_we, freg_wdata, zero_flag}, 10'h201)
    issue(OP_REG_MINUS, 11'h004, 8'h00, 1'h0);
    `CHK({accumulator, zero_flag}, 9'h1fe)
  endtask
  task automatic t_skip();
    p = pc;
    issue(OP_MINUS_SKIP, 11'h005, 8'h01, 1'h0);
    `CHK({accumulator, zero_flag}, 9'h000)
    `CHK({busy, flushing, pc}, {2'h3, p + 13'h0001})
    @(posedge clk) #1;
    `CHK({busy, pc}, {1'h0, p + 13'h0002})
    issue(OP_MINUS_SKIP, 11'h006, 8'h05, 1'h1);
    `CHK({busy, freg_we, freg_wdata}, 10'h104)
  endtask
  initial begin
    clk = 1'h0;
    nrst = 1'h0;
    instr_valid = 1'h0;
    instr_op = OP_NOP;
    instr_lit = 11'h000;
    instr_faddr = 7'h00;
    instr_dest = 1'h0;
    page_latch = 8'h00;
    freg_rdata = 8'h00;
    repeat (12) @(posedge clk);
    nrst <= 1'h1;
    t_call();
    t_kick();
    t_clear();
    t_dec();
    t_skip();
    give_verdict();
  end
endmodule
